// ---- verilog/dmac_regs.svh ----
// Register map, field positions and reset values of the DMA controller.
// Assumes inclusion by bare name from the package, checker and bench files.
`ifndef DMAC_REGS_SVH
`define DMAC_REGS_SVH
// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define DMAC_NCH 8
`define DMAC_CNTW 17
// ----------------------------------------------------------------
// Offsets: channel slot is paddr[7:5], register is paddr[4:0]
// ----------------------------------------------------------------
`define DMAC_CFG_OFF 5'h00
`define DMAC_CNT_OFF 5'h04
`define DMAC_PBASE_OFF 5'h08
`define DMAC_MBASE_OFF 5'h0C
`define DMAC_FLAG_OFF 12'h100
`define DMAC_FCLR_OFF 12'h104
`define DMAC_SWTRIG_OFF 12'h108
// ----------------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------------
`define DMAC_CFG_EN 0
`define DMAC_CFG_HTIE 1
`define DMAC_CFG_TCIE 2
`define DMAC_CFG_DIR 3
`define DMAC_CFG_CIRC 4
`define DMAC_CFG_PINC 5
`define DMAC_CFG_MINC 6
`define DMAC_CFG_PSIZE 7
`define DMAC_CFG_MSIZE 9
`define DMAC_CFG_PL 11
`define DMAC_CFG_M2M 13
`define DMAC_CFGW 14
`define DMAC_CFG_RST 14'h0000
`endif

// ---- verilog/dmac_pkg.sv ----
// Types of the DMA controller: channel state and module state records.
// Assumes dmac_regs.svh is on the include path.
`include "dmac_regs.svh"
package dmac_pkg;
  // Transfer sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dmac_state_t;
  // One channel's programmed and running state
  typedef struct packed {
    logic [`DMAC_CFGW-1:0] cfg;
    logic [`DMAC_CNTW-1:0] npro;
    logic [`DMAC_CNTW-1:0] cnt;
    logic [31:0] pbase;
    logic [31:0] mbase;
    logic [31:0] pcur;
    logic [31:0] mcur;
    logic ht;
    logic tc;
    logic ack;
    logic sw;
    logic irq;
  } dmac_ch_t;
  // Whole controller state
  typedef struct packed {
    dmac_ch_t [`DMAC_NCH-1:0] ch;
    dmac_state_t state;
    logic [2:0] sel;
    logic by_req;
    logic [31:0] data;
    logic sb_valid;
    logic sb_we;
    logic [31:0] sb_addr;
    logic [1:0] sb_size;
    logic [31:0] sb_wdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dmac_top_t;
  // Bus matrix grant state
  typedef struct packed {
    logic gnt_cpu;
    logic gnt_dma;
    logic last_dma;
  } dmac_rr_t;
endpackage

// ---- verilog/dmac_chan_arb.sv ----
// Channel picker: highest software level wins, lower index breaks ties.
// Assumes pending and level vectors are stable within the cycle.
module dmac_chan_arb
  import dmac_pkg::*;
(
  input wire logic [`DMAC_NCH-1:0] pend,
  input wire logic [2*`DMAC_NCH-1:0] lvl,
  output logic any,
  output logic [2:0] idx
);
  // ----------------------------------------------------------------
  // Scan from the top index down so lower indexes overwrite on ties
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] best;
    best = 2'h0;
    any = 1'b0;
    idx = 3'h0;
    for (int i = `DMAC_NCH - 1; i >= 0; i--) begin
      // Higher level, or equal level at lower index
      if (pend[i] && (!any || lvl[2*i +: 2] >= best)) begin
        any = 1'b1;
        best = lvl[2*i +: 2];
        idx = i[2:0];
      end
    end
  end
endmodule

// ---- verilog/dmac_rr_arb.sv ----
// Round-robin bus matrix grant between the processor and the controller.
// Assumes each owner signals the end of its access with a done pulse.
module dmac_rr_arb
  import dmac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_req,
  input wire logic cpu_done,
  input wire logic dma_req,
  input wire logic dma_done,
  output logic gnt_cpu,
  output logic gnt_dma
);
  dmac_rr_t s_ff; // Grant state
  dmac_rr_t nxt_s; // Next grant state
  // ----------------------------------------------------------------
  // Grant per access; when both want the bus, alternate owners
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    if (s_ff.gnt_cpu) begin
      // Processor access ends, free the bus
      if (cpu_done) nxt_s.gnt_cpu = 1'b0;
    end else if (s_ff.gnt_dma) begin
      // Controller access ends, free the bus
      if (dma_done) nxt_s.gnt_dma = 1'b0;
    end else if (cpu_req && (!dma_req || s_ff.last_dma)) begin
      // Processor gets every other slot at least
      nxt_s.gnt_cpu = 1'b1;
      nxt_s.last_dma = 1'b0;
    end else if (dma_req) begin
      nxt_s.gnt_dma = 1'b1;
      nxt_s.last_dma = 1'b1;
    end
  end
  // Grant registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_ff <= '0;
    else s_ff <= nxt_s;
  end
  assign gnt_cpu = s_ff.gnt_cpu;
  assign gnt_dma = s_ff.gnt_dma;
endmodule

// ---- verilog/dmac_top.sv ----
// Eight-channel DMA controller with APB registers and a system bus master.
// Assumes APB and system bus are synchronous to pclk; peripherals use
// a four-phase request and acknowledge handshake.
//
// Behaviour
// - Eight channels, own request line, software trigger
// - Four software priority levels order service
// - Equal level: lower channel index first
// - Independent source and destination widths
// - Circular buffer mode on any channel
// - Half and complete flags ORed into irq
// - All peripheral and memory transfer directions
// - Item count programmable up to 65536; the count register takes up to 0x1FFFF
// - Shares system bus with the processor
// - Round-robin gives processor half the bandwidth
// - Peripheral requests; served by channel priority
// - Acknowledge when peripheral access is performed
// - Acknowledge held until request removed
// - Read source at current address, from base
// - Write item to destination current address
// - Decrement remaining count after each transfer
// - Increment address by 1, 2 or 4
// - Non-circular: count zero stops service
// - Circular: reload count and both addresses
//
// Design decisions made here: the APB register port and the register addresses.
module dmac_top
  import dmac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`DMAC_NCH-1:0] per_req,
  output logic [`DMAC_NCH-1:0] per_ack,
  output logic [`DMAC_NCH-1:0] ch_irq,
  output logic sb_valid,
  output logic sb_we,
  output logic [31:0] sb_addr,
  output logic [1:0] sb_size,
  output logic [31:0] sb_wdata,
  input wire logic [31:0] sb_rdata,
  input wire logic sb_ready,
  input wire logic cpu_req,
  input wire logic cpu_done,
  output logic cpu_gnt
);
  // ----------------------------------------------------------------
  // State and helper nets
  // ----------------------------------------------------------------
  dmac_top_t s_ff; // All controller state
  dmac_top_t nxt_s; // Next controller state
  logic [`DMAC_NCH-1:0] pend; // Channels ready for service
  logic [2*`DMAC_NCH-1:0] lvl; // Software priority per channel
  logic pick_any; // Some channel is pending
  logic [2:0] pick_idx; // Winning channel
  logic dma_gnt; // Controller owns the system bus
  logic bus_done; // Current bus access completes this edge
  logic dma_want; // Controller asks the matrix for the bus

  // ----------------------------------------------------------------
  // Per-channel pending terms and outputs
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `DMAC_NCH; g++) begin : g_ch
    // Enabled, items left, and a request, trigger or free-running m2m
    assign pend[g] = s_ff.ch[g].cfg[`DMAC_CFG_EN]
      && (s_ff.ch[g].cnt != '0)
      && (s_ff.ch[g].cfg[`DMAC_CFG_M2M] || s_ff.ch[g].sw
      || (per_req[g] && !s_ff.ch[g].ack));
    assign lvl[2*g +: 2] = s_ff.ch[g].cfg[`DMAC_CFG_PL +: 2];
    assign per_ack[g] = s_ff.ch[g].ack;
    assign ch_irq[g] = s_ff.ch[g].irq;
  end

  // ----------------------------------------------------------------
  // Channel priority picker
  // ----------------------------------------------------------------
  dmac_chan_arb u_chan_arb (
    .pend(pend),
    .lvl(lvl),
    .any(pick_any),
    .idx(pick_idx)
  );

  // ----------------------------------------------------------------
  // Bus matrix shared with the processor
  // ----------------------------------------------------------------
  assign bus_done = s_ff.sb_valid && sb_ready;
  assign dma_want = (s_ff.state != ST_IDLE) && !bus_done;
  dmac_rr_arb u_rr_arb (
    .pclk(pclk),
    .presetn(presetn),
    .cpu_req(cpu_req),
    .cpu_done(cpu_done),
    .dma_req(dma_want),
    .dma_done(bus_done),
    .gnt_cpu(cpu_gnt),
    .gnt_dma(dma_gnt)
  );

  // ----------------------------------------------------------------
  // Next-state logic: APB registers, handshake, transfer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] c;
    logic [4:0] r;
    logic setup;
    logic wr;
    logic per_side;
    logic [`DMAC_CNTW-1:0] left;
    logic [31:0] item;
    logic [1:0] ss;
    c = paddr[7:5];
    r = paddr[4:0];
    setup = psel && !penable;
    wr = psel && penable && s_ff.pready && pwrite;
    per_side = 1'b0;
    left = '0;
    item = '0;
    ss = 2'h0;
    nxt_s = s_ff;
    // Acknowledge falls once the request is gone
    for (int i = 0; i < `DMAC_NCH; i++) begin
      if (!per_req[i]) nxt_s.ch[i].ack = 1'b0;
    end
    // APB: answer one cycle after setup, data and error prepared here
    nxt_s.pready = setup;
    if (setup) begin
      nxt_s.prdata = 32'h0000_0000;
      nxt_s.pslverr = 1'b0;
      if (!paddr[8]) begin
        // Channel slot
        if (r == `DMAC_CFG_OFF) nxt_s.prdata[`DMAC_CFGW-1:0] = s_ff.ch[c].cfg;
        else if (r == `DMAC_CNT_OFF) nxt_s.prdata[`DMAC_CNTW-1:0] = s_ff.ch[c].cnt;
        else if (r == `DMAC_PBASE_OFF) nxt_s.prdata = s_ff.ch[c].pbase;
        else if (r == `DMAC_MBASE_OFF) nxt_s.prdata = s_ff.ch[c].mbase;
        else nxt_s.pslverr = 1'b1;
      end else if (paddr == `DMAC_FLAG_OFF) begin
        // Flags: complete in 15:8, half in 7:0
        for (int i = 0; i < `DMAC_NCH; i++) begin
          nxt_s.prdata[i] = s_ff.ch[i].ht;
          nxt_s.prdata[i+8] = s_ff.ch[i].tc;
        end
      end else if (paddr == `DMAC_SWTRIG_OFF) begin
        for (int i = 0; i < `DMAC_NCH; i++) nxt_s.prdata[i] = s_ff.ch[i].sw;
      end else if (paddr != `DMAC_FCLR_OFF) begin
        // Unmapped address
        nxt_s.pslverr = 1'b1;
      end
    end
    // APB writes at the access edge
    if (wr && !paddr[8]) begin
      if (r == `DMAC_CFG_OFF) begin
        nxt_s.ch[c].cfg = pwdata[`DMAC_CFGW-1:0];
        // Enable edge starts from the bases and programmed count
        if (pwdata[`DMAC_CFG_EN] && !s_ff.ch[c].cfg[`DMAC_CFG_EN]) begin
          nxt_s.ch[c].pcur = s_ff.ch[c].pbase;
          nxt_s.ch[c].mcur = s_ff.ch[c].mbase;
          nxt_s.ch[c].cnt = s_ff.ch[c].npro;
        end
      end else if (r == `DMAC_CNT_OFF && !s_ff.ch[c].cfg[`DMAC_CFG_EN]) begin
        // Count only taken while disabled; 0x1FFFF is the largest
        nxt_s.ch[c].npro = pwdata[`DMAC_CNTW-1:0];
        nxt_s.ch[c].cnt = pwdata[`DMAC_CNTW-1:0];
      end else if (r == `DMAC_PBASE_OFF) begin
        nxt_s.ch[c].pbase = pwdata;
      end else if (r == `DMAC_MBASE_OFF) begin
        nxt_s.ch[c].mbase = pwdata;
      end
    end else if (wr && paddr == `DMAC_FCLR_OFF) begin
      // Write one to clear; hardware set below wins
      for (int i = 0; i < `DMAC_NCH; i++) begin
        if (pwdata[i]) nxt_s.ch[i].ht = 1'b0;
        if (pwdata[i+8]) nxt_s.ch[i].tc = 1'b0;
      end
    end else if (wr && paddr == `DMAC_SWTRIG_OFF) begin
      // Software trigger per channel
      for (int i = 0; i < `DMAC_NCH; i++) begin
        if (pwdata[i]) nxt_s.ch[i].sw = 1'b1;
      end
    end
    // System bus strobe follows the grant
    nxt_s.sb_valid = (s_ff.state != ST_IDLE) && dma_gnt && !bus_done;
    // Transfer sequencer
    c = s_ff.sel;
    per_side = !s_ff.ch[c].cfg[`DMAC_CFG_M2M] && s_ff.by_req;
    case (s_ff.state)
      ST_IDLE: begin
        if (pick_any) begin
          // Start with the source read at its current address
          nxt_s.sel = pick_idx;
          nxt_s.by_req = !s_ff.ch[pick_idx].sw;
          nxt_s.state = ST_RD;
          nxt_s.sb_we = 1'b0;
          if (s_ff.ch[pick_idx].cfg[`DMAC_CFG_DIR]) begin
            nxt_s.sb_addr = s_ff.ch[pick_idx].mcur;
            nxt_s.sb_size = s_ff.ch[pick_idx].cfg[`DMAC_CFG_MSIZE +: 2];
          end else begin
            nxt_s.sb_addr = s_ff.ch[pick_idx].pcur;
            nxt_s.sb_size = s_ff.ch[pick_idx].cfg[`DMAC_CFG_PSIZE +: 2];
          end
        end
      end
      ST_RD: begin
        if (bus_done) begin
          // Keep only the source width, zero-extended
          ss = s_ff.sb_size;
          if (ss == 2'h0) item = {24'h00_0000, sb_rdata[7:0]};
          else if (ss == 2'h1) item = {16'h0000, sb_rdata[15:0]};
          else item = sb_rdata;
          nxt_s.data = item;
          nxt_s.sb_wdata = item;
          nxt_s.sb_we = 1'b1;
          nxt_s.state = ST_WR;
          // Peripheral is the source: acknowledge on its access
          if (!s_ff.ch[c].cfg[`DMAC_CFG_DIR] && per_side) nxt_s.ch[c].ack = 1'b1;
          // Destination at its current address
          if (s_ff.ch[c].cfg[`DMAC_CFG_DIR]) begin
            nxt_s.sb_addr = s_ff.ch[c].pcur;
            nxt_s.sb_size = s_ff.ch[c].cfg[`DMAC_CFG_PSIZE +: 2];
          end else begin
            nxt_s.sb_addr = s_ff.ch[c].mcur;
            nxt_s.sb_size = s_ff.ch[c].cfg[`DMAC_CFG_MSIZE +: 2];
          end
        end
      end
      ST_WR: begin
        if (bus_done) begin
          nxt_s.state = ST_IDLE;
          nxt_s.sb_we = 1'b0;
          // Peripheral is the destination: acknowledge now
          if (s_ff.ch[c].cfg[`DMAC_CFG_DIR] && per_side) nxt_s.ch[c].ack = 1'b1;
          if (!s_ff.by_req) nxt_s.ch[c].sw = 1'b0;
          // One item moved
          left = s_ff.ch[c].cnt - `DMAC_CNTW'(1);
          nxt_s.ch[c].cnt = left;
          // Post-increment by the side's width
          if (s_ff.ch[c].cfg[`DMAC_CFG_PINC]) begin
            nxt_s.ch[c].pcur = s_ff.ch[c].pcur
              + (32'h0000_0001 << s_ff.ch[c].cfg[`DMAC_CFG_PSIZE +: 2]);
          end
          if (s_ff.ch[c].cfg[`DMAC_CFG_MINC]) begin
            nxt_s.ch[c].mcur = s_ff.ch[c].mcur
              + (32'h0000_0001 << s_ff.ch[c].cfg[`DMAC_CFG_MSIZE +: 2]);
          end
          // Half of the programmed items done
          if (left == (s_ff.ch[c].npro >> 1)) nxt_s.ch[c].ht = 1'b1;
          if (left == '0) begin
            // All done; the count stays at zero unless circular
            nxt_s.ch[c].tc = 1'b1;
            if (s_ff.ch[c].cfg[`DMAC_CFG_CIRC]) begin
              // Reload for a continuous flow
              nxt_s.ch[c].cnt = s_ff.ch[c].npro;
              nxt_s.ch[c].pcur = s_ff.ch[c].pbase;
              nxt_s.ch[c].mcur = s_ff.ch[c].mbase;
            end
          end
        end
      end
      default: begin
        nxt_s.state = ST_IDLE;
      end
    endcase
    // One interrupt line per channel from both enabled flags
    for (int i = 0; i < `DMAC_NCH; i++) begin
      nxt_s.ch[i].irq = (nxt_s.ch[i].ht && nxt_s.ch[i].cfg[`DMAC_CFG_HTIE])
        || (nxt_s.ch[i].tc && nxt_s.ch[i].cfg[`DMAC_CFG_TCIE]);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  // ----------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------
  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign sb_valid = s_ff.sb_valid;
  assign sb_we = s_ff.sb_we;
  assign sb_addr = s_ff.sb_addr;
  assign sb_size = s_ff.sb_size;
  assign sb_wdata = s_ff.sb_wdata;
endmodule

// ---- tb/dmac_top_asserts.sv ----
// Checker on the DMA controller ports: handshake, system bus and bus sharing.
// Assumes it is bound to dmac_top and sees only that module's ports.
`include "dmac_regs.svh"
module dmac_top_asserts
  import dmac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`DMAC_NCH-1:0] per_req,
  input wire logic [`DMAC_NCH-1:0] per_ack,
  input wire logic sb_valid,
  input wire logic sb_we,
  input wire logic [31:0] sb_addr,
  input wire logic [1:0] sb_size,
  input wire logic [31:0] sb_wdata,
  input wire logic sb_ready,
  input wire logic cpu_done,
  input wire logic cpu_gnt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Helper: a read finished, its write is owed
  // ----------------------------------------
  logic rd_open_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_open_ff <= 1'h0;
    end else if (sb_valid && sb_ready) begin
      rd_open_ff <= !sb_we;
    end
  end
  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  a_ack_hold: assert property (
    (per_ack & $past(per_ack & per_req)) == $past(per_ack & per_req))
    else $error("acknowledge dropped while request still high");
  a_ack_release: assert property (
    (per_ack & $past(per_ack & ~per_req)) == '0)
    else $error("acknowledge kept after request removed");
  a_ack_after_access: assert property (
    (per_ack & ~$past(per_ack)) != '0 |-> $past(sb_valid && sb_ready))
    else $error("acknowledge rose without a finished bus access");
  a_ack_needs_req: assert property (
    (per_ack & ~$past(per_ack) & ~$past(per_req)) == '0)
    else $error("acknowledge rose without a request");
  a_bus_shared: assert property (!(cpu_gnt && sb_valid))
    else $error("controller strobe while processor owns the bus");
  a_sb_stable: assert property (
    sb_valid && !sb_ready |=> sb_valid && $stable(sb_addr) && $stable(sb_we)
      && $stable(sb_size) && $stable(sb_wdata))
    else $error("bus request changed before it was answered");
  a_read_first: assert property (sb_valid |-> sb_we == rd_open_ff)
    else $error("bus accesses not paired read then write");
  a_cpu_release: assert property (cpu_gnt && cpu_done |=> !cpu_gnt)
    else $error("processor grant kept after its access ended");
  c_ack: cover property ((per_ack & ~$past(per_ack)) != '0);
  c_write: cover property (sb_valid && sb_ready && sb_we);
  c_cpu_then_dma: cover property (cpu_gnt ##1 !cpu_gnt ##[1:8] sb_valid);
endmodule
bind dmac_top dmac_top_asserts i_dmac_top_asserts (
  .pclk(pclk), .presetn(presetn), .per_req(per_req), .per_ack(per_ack),
  .sb_valid(sb_valid), .sb_we(sb_we), .sb_addr(sb_addr), .sb_size(sb_size),
  .sb_wdata(sb_wdata), .sb_ready(sb_ready), .cpu_done(cpu_done), .cpu_gnt(cpu_gnt)
);

// ---- tb/dmac_bus_model.sv ----
// Far side of the DMA controller: system bus memory and eight peripherals.
// Assumes the controller's clock and reset; event pulses come from the bench.
module dmac_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sb_valid,
  input wire logic sb_we,
  input wire logic [31:0] sb_addr,
  input wire logic [31:0] sb_wdata,
  output logic [31:0] sb_rdata,
  output logic sb_ready,
  input wire logic [7:0] per_ack,
  input wire logic [7:0] fire,
  output logic [7:0] per_req,
  output logic [15:0] wr_cnt,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [31:0] rd_addr
);
  logic [1:0] wt_ff;
  // ----------------------------------------
  // Memory: 0 to 3 wait states chosen by address
  // ----------------------------------------
  assign sb_ready = sb_valid && (wt_ff == sb_addr[3:2]);
  // Data valid only while answering, a moving pattern otherwise
  assign sb_rdata = sb_ready ? {~sb_addr[15:0], sb_addr[15:0]} : {30'h0, wt_ff} ^ ~sb_addr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wt_ff <= 2'h0;
      wr_cnt <= 16'h0000;
    end else begin
      wt_ff <= sb_ready ? 2'h0 : wt_ff + 2'(sb_valid);
      wr_cnt <= wr_cnt + 16'(sb_ready & sb_we);
    end
  end
  // Last write and last read, for the bench to compare
  always_ff @(posedge pclk) begin
    if (sb_ready && sb_we) begin
      wr_addr <= sb_addr;
      wr_data <= sb_wdata;
    end else if (sb_ready) begin
      rd_addr <= sb_addr;
    end
  end
  // ----------------------------------------
  // Peripherals: raise while ack low, drop on ack
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_req <= 8'h00;
    end else begin
      per_req <= (per_req | (fire & ~per_ack)) & ~per_ack;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench of the DMA controller with random addresses and bus load.
// Assumes the package, the design, the checker and dmac_bus_model come first.
`include "dmac_regs.svh"
module tb_top
  import dmac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, sb_addr, sb_wdata, sb_rdata, rd_addr, wr_addr, wr_data;
  logic [31:0] rv, r, pb, mb;
  logic [`DMAC_NCH-1:0] per_req, per_ack, ch_irq, fire;
  logic sb_valid, sb_we, sb_ready, cpu_req, cpu_done, cpu_gnt;
  logic [1:0] sb_size;
  logic [15:0] wr_cnt, wc0;
  int mismatches, cmp_count, seed, cycles;
  // ----------------------------------------
  // Design, far side, clock and processor load
  // ----------------------------------------
  dmac_top i_dmac_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .per_req(per_req), .per_ack(per_ack), .ch_irq(ch_irq), .sb_valid(sb_valid),
    .sb_we(sb_we), .sb_addr(sb_addr), .sb_size(sb_size), .sb_wdata(sb_wdata),
    .sb_rdata(sb_rdata), .sb_ready(sb_ready), .cpu_req(cpu_req), .cpu_done(cpu_done),
    .cpu_gnt(cpu_gnt)
  );
  dmac_bus_model i_dmac_bus_model (
    .pclk(pclk), .presetn(presetn), .sb_valid(sb_valid), .sb_we(sb_we), .sb_addr(sb_addr),
    .sb_wdata(sb_wdata), .sb_rdata(sb_rdata), .sb_ready(sb_ready), .per_ack(per_ack),
    .fire(fire), .per_req(per_req), .wr_cnt(wr_cnt), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr)
  );
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // Random processor traffic; a hang ends the run as a mismatch
  always @(posedge pclk) begin
    r = $random(seed);
    cpu_req <= r[0];
    cpu_done <= cpu_gnt & ~cpu_done & r[1];
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rdv(input logic [31:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  function automatic logic [31:0] cf(input logic [31:0] f, input int ps, ms, lv);
    return f | 32'(ps << 7 | ms << 9 | lv << 11);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    // No answer within the limit counts against the run
    if (n == 50) mismatches++;
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task prog(input int c, input logic [31:0] f, n, p, m);
    apb(1, 12'(c * 32 + 8), p);
    apb(1, 12'(c * 32 + 12), m);
    apb(1, 12'(c * 32 + 4), n);
    apb(1, 12'(c * 32), f);
  endtask
  // Peripheral events, once their acknowledges are low
  task pulse(input logic [7:0] m);
    int n;
    n = 0;
    while ((per_ack & m) !== 8'h00 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    // Acknowledge stuck high counts against the run
    if (n == 100) mismatches++;
    @(posedge pclk);
    fire <= m;
    @(posedge pclk);
    fire <= 8'h00;
  endtask
  // Wait for the next item written and compare both addresses and data
  task wr_chk(input logic [31:0] ra, wa, d);
    int n;
    n = 0;
    while (wr_cnt === wc0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    // No write within the limit counts against the run
    if (n == 2000) mismatches++;
    wc0 = wr_cnt;
    chk(rd_addr, ra);
    chk(wr_addr, wa);
    chk(wr_data, d);
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 31300;
    presetn = 1'h0;
    {psel, penable, pwrite, cpu_req, cpu_done} = 5'h00;
    {paddr, pwdata, fire, wc0} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(0, 12'h000, '0);
    chk(rv, '0);
    apb(1, 12'h1f0, 32'hffff_ffff);
    chk(ev, 1);
    $display("test reset done");
    pb = $random(seed) & 32'hffff_fffc;
    mb = $random(seed) & 32'hffff_fffc;
    prog(0, cf(32'h0000_0047, 0, 1, 0), 4, pb, mb);
    for (int i = 0; i < 4; i++) begin
      pulse(8'h01);
      wr_chk(pb, mb + 32'(2 * i), rdv(pb) & 32'h0000_00ff);
      chk(32'(sb_size), 32'h0000_0001);
      apb(0, 12'h100, '0);
      chk(rv, i < 1 ? 0 : i < 3 ? 1 : 32'h0000_0101);
    end
    apb(0, 12'h004, '0);
    chk(rv, '0);
    chk(ch_irq, 8'h01);
    pulse(8'h21);
    repeat (40) @(posedge pclk);
    chk(wr_cnt, wc0);
    chk(per_ack, '0);
    apb(1, 12'h104, 32'h0000_0101);
    repeat (3) @(posedge pclk);
    chk(ch_irq, '0);
    apb(1, 12'h000, '0);
    $display("test single channel done");
    for (int c = 1; c < 4; c++) prog(c, cf(32'h0000_0041, 2, 2, c == 1 ? 1 : 3), 1, pb, mb + 32'(c * 256));
    pulse(8'h0e);
    for (int k = 1; k < 4; k++) wr_chk(pb, mb + 32'((k % 3 + 1) * 256), rdv(pb));
    $display("test priority done");
    prog(4, cf(32'h0000_0039, 1, 0, 2), 2, pb, mb);
    for (int i = 0; i < 3; i++) begin
      pulse(8'h10);
      wr_chk(mb, pb + 32'(i % 2 * 2), rdv(mb) & 32'h0000_00ff);
      chk(32'(sb_size), 32'h0000_0001);
    end
    apb(1, 12'h080, '0);
    $display("test circular done");
    prog(6, cf(32'h0000_0001, 2, 2, 0), 1, pb, mb);
    apb(1, 12'h108, 32'h0000_0040);
    wr_chk(pb, mb, rdv(pb));
    prog(7, cf(32'h0000_2061, 2, 2, 0), 2, pb, mb);
    wr_chk(pb, mb, rdv(pb));
    wr_chk(pb + 4, mb + 4, rdv(pb + 4));
    apb(1, 12'h0a4, 32'h0001_0000);
    apb(0, 12'h0a4, '0);
    chk(rv, 32'h0001_0000);
    $display("test trigger and memory copy done");
    finish_test();
  end
endmodule
